/* File: logic/rc_config_regs.sv */
// apb register bank and field decoders of the range compressor channel
// Functional notes
// [R1] bit 7 picks peak (0) or rms (1) detection, bit 6 enables; both reset 0
// [R2] knee-2 output level in 20:16 used only while bit 5 is set
// [R3] knee-2 output level: -30 dB at 0, -1.5 dB per code, reset 0
// [R4] knee-2 input 28:24: -36 dB, -1.5 dB steps, only with gate enabled
// [R5] knee-1 input 13:8: 0 dB, -0.75 dB steps to 0x3C, above reserved
// [R6] knee-1 output 4:0: 0 dB, -0.75 dB steps to 0x1E, 0x1F reserved
// [R7] gate floor gain 15:12: -36 dB plus 6 dB per code, applied while gate active
// [R8] gate expansion slope 11:10 gives 1, 2, 4 or 8
// [R9] fast release enable bit 4 resets 1; threshold 9:8 gives 12 to 30 dB
// [R10] fast release decay 7:6: 0.725, 1.45, 5.8 ms; code 3 reserved
// [R11] upper slope 5:3: 1, 1/2, 1/4, 1/8, 1/16, 0; reset 011
// [R12] lower slope 2:0: 1, 1/2, 1/4, 0 at 100; others reserved
// [R13] peak mode flags detection when crest factor exceeds the chosen threshold
// [R14] software must not write reserved codes; they are only flagged here
`timescale 1ns/10ps
module rc_config_regs
    import rc_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_psel,
    input  wire logic       i_penable,
    input  wire logic       i_pwrite,
    input  wire rc_addr_t   i_paddr,
    input  wire rc_word_t   i_pwdata,
    input  wire logic [3:0] i_pstrb,
    input  wire logic       i_level_valid,
    input  wire rc_qdb_t    i_crest_level,
    input  wire rc_qdb_t    i_rms_level,
    input  wire logic       i_gate_active,
    output rc_word_t        o_prdata,
    output logic            o_pready,
    output logic            o_pslverr,
    output rc_cfg_s         o_cfg,
    output logic            o_signal_detect
);

    rc_word_t options_reg;
    rc_word_t gate_reg;
    rc_word_t knees_reg;
    rc_word_t prdata_next;
    rc_word_t status_word;
    rc_word_t wmask;
    rc_cfg_s  cfg_next;
    logic     mapped;
    logic     setup;
    logic     access;
    logic     wr_options;
    logic     wr_gate;
    logic     wr_knees;
    logic     wr_status;
    logic     status_clear;
    logic     peak_hit;
    logic     rms_hit;
    logic     det_next;
    logic     sticky_reserved_reg;

    // linear level decode: base plus step per code
    function automatic rc_qdb_t lin_qdb(input rc_qdb_t    base,
                                        input rc_qdb_t    step,
                                        input logic [5:0] code);
        rc_qdb_t c;
        c = rc_qdb_t'({6'h00, code});
        return rc_qdb_t'(base + step * c);
    endfunction

    // byte strobes widened to a bit mask
    function automatic rc_word_t strobe_mask(input logic [3:0] strb);
        rc_word_t m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // write strobe of one register: access phase of a write to its address
    function automatic logic reg_hit(input logic acc, input logic wr,
                                     input rc_addr_t addr, input rc_addr_t ofs);
        return acc & wr & (addr == ofs);
    endfunction

    // byte-lane merge of write data, bits outside keep hold their value
    function automatic rc_word_t merge_bytes(input rc_word_t old_val,
                                             input rc_word_t new_val,
                                             input rc_word_t keep);
        return (old_val & ~keep) | (new_val & keep);
    endfunction

    // compressor slope code to 1/16 units, flags reserved codes
    function automatic logic [5:0] slope_dec(input logic [2:0] code,
                                             input logic       lower);
        logic [5:0] r;
        r = 6'h20;
        case (code)
            3'b000:  r = 6'h10;
            3'b001:  r = 6'h08;
            3'b010:  r = 6'h04;
            3'b011:  r = lower ? 6'h20 : 6'h02;
            3'b100:  r = lower ? 6'h00 : 6'h01;
            3'b101:  r = lower ? 6'h20 : 6'h00;
            default: r = 6'h20;
        endcase
        return r;
    endfunction

    // apb phase decode
    assign setup  = i_psel & ~i_penable;
    assign access = i_psel & i_penable & o_pready;

    // byte-lane write mask
    assign wmask  = strobe_mask(i_pstrb);

    // per-register write strobes at the access edge
    assign wr_options   = reg_hit(access, i_pwrite, i_paddr, RC_OFS_OPTIONS);
    assign wr_gate      = reg_hit(access, i_pwrite, i_paddr, RC_OFS_GATE);
    assign wr_knees     = reg_hit(access, i_pwrite, i_paddr, RC_OFS_KNEES);
    assign wr_status    = reg_hit(access, i_pwrite, i_paddr, RC_OFS_STATUS);
    assign status_clear = wr_status & i_pstrb[0] & i_pwdata[1]; // [R14]

    // status word: sticky reserved-code flag over live detect
    assign status_word = {30'h0, sticky_reserved_reg, o_signal_detect};

    // read mux and address map
    always_comb begin
        mapped      = 1'b1;
        prdata_next = '0;
        case (i_paddr)
            RC_OFS_OPTIONS: prdata_next = options_reg;
            RC_OFS_GATE:    prdata_next = gate_reg;
            RC_OFS_KNEES:   prdata_next = knees_reg;
            RC_OFS_STATUS:  prdata_next = status_word;
            default:        mapped      = 1'b0;
        endcase
    end

    // zero-wait answer: ready high in the access cycle, one cycle after setup
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= setup;
        end
    end

    // error answer for an unmapped address, alongside ready
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_pslverr <= 1'b0;
        end else begin
            o_pslverr <= setup & ~mapped;
        end
    end

    // read data captured in the setup cycle, held until the next read
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_prdata <= '0;
        end else if (setup && !i_pwrite) begin
            o_prdata <= prdata_next;
        end
    end

    // detection options register, writes land at the access edge
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            options_reg <= RC_RST_OPTIONS; // [R1] [R9]
        end else if (wr_options) begin
            options_reg <= merge_bytes(options_reg, i_pwdata, wmask & RC_MASK_OPTIONS);
        end
    end

    // gate, release and slope register
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            gate_reg <= RC_RST_GATE; // [R11]
        end else if (wr_gate) begin
            gate_reg <= merge_bytes(gate_reg, i_pwdata, wmask & RC_MASK_GATE);
        end
    end

    // knee level register
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            knees_reg <= RC_RST_KNEES; // [R3] [R4] [R5] [R6]
        end else if (wr_knees) begin
            knees_reg <= merge_bytes(knees_reg, i_pwdata, wmask & RC_MASK_KNEES);
        end
    end

    // field decode into the datapath configuration
    always_comb begin
        logic [5:0] up;
        logic [5:0] lo;
        logic       rsv;
        up       = slope_dec(gate_reg[RC_B_UPPER_LO +: 3], 1'b0); // [R11]
        lo       = slope_dec(gate_reg[RC_B_LOWER_LO +: 3], 1'b1); // [R12]
        rsv      = up[5] | lo[5];
        cfg_next = '0;
        cfg_next.detect_mode_select   = options_reg[RC_B_MODE];    // [R1]
        cfg_next.detect_enable        = options_reg[RC_B_DET_EN];  // [R1]
        cfg_next.gate_enable          = options_reg[RC_B_GATE_EN];
        cfg_next.gate_knee_out_enable = options_reg[RC_B_K2O_EN];  // [R2]
        cfg_next.fast_release_enable  = options_reg[RC_B_FR_EN];   // [R9]
        cfg_next.clip_guard_enable    = options_reg[RC_B_CLIP_EN];
        cfg_next.detect_peak_threshold = lin_qdb(RC_Q_PEAK_BASE, RC_Q_STEP_6DB,
            {4'h0, options_reg[RC_B_PEAK_LO +: 2]}); // [R13]
        cfg_next.detect_rms_threshold = lin_qdb(RC_Q_RMS_BASE, RC_Q_STEP_1P5,
            {1'b0, options_reg[RC_B_RMS_LO +: 5]});
        // floor gain only while the gate is enabled and closing
        cfg_next.gate_floor_gain = lin_qdb(RC_Q_FLOOR_BASE, RC_Q_STEP_6DB,
            {2'b00, gate_reg[RC_B_FLOOR_LO +: 4]}); // [R7]
        cfg_next.gate_floor_apply = options_reg[RC_B_GATE_EN] & i_gate_active; // [R7]
        if (gate_reg[RC_B_FLOOR_LO +: 4] > RC_FLOOR_MAX) begin
            rsv = 1'b1; // [R7]
        end
        cfg_next.gate_expansion_slope = 4'h1 << gate_reg[RC_B_EXP_LO +: 2]; // [R8]
        cfg_next.fast_release_threshold = lin_qdb(RC_Q_PEAK_BASE, RC_Q_STEP_6DB,
            {4'h0, gate_reg[RC_B_FRT_LO +: 2]}); // [R9]
        case (gate_reg[RC_B_FRD_LO +: 2]) // [R10]
            2'b00:   cfg_next.fast_release_decay = RC_US_DCY0;
            2'b01:   cfg_next.fast_release_decay = RC_US_DCY1;
            2'b10:   cfg_next.fast_release_decay = RC_US_DCY2;
            default: begin
                cfg_next.fast_release_decay = RC_US_DCY2;
                rsv = 1'b1;
            end
        endcase
        cfg_next.upper_compress_slope = up[4:0];
        cfg_next.lower_compress_slope = lo[4:0];
        cfg_next.gate_knee_in_level = lin_qdb(RC_Q_K2I_BASE, RC_Q_STEP_1P5,
            {1'b0, knees_reg[RC_B_K2I_LO +: 5]}); // [R4]
        cfg_next.gate_knee_in_active = options_reg[RC_B_GATE_EN]; // [R4]
        // knee-2 output level reads as 0 dB while its enable is clear
        if (options_reg[RC_B_K2O_EN]) begin
            cfg_next.gate_knee_out_level = lin_qdb(RC_Q_RMS_BASE, RC_Q_STEP_1P5,
                {1'b0, knees_reg[RC_B_K2O_LO +: 5]}); // [R2] [R3]
        end else begin
            cfg_next.gate_knee_out_level = RC_Q_ZERO; // [R2]
        end
        cfg_next.compress_knee_in_level = lin_qdb(RC_Q_ZERO, RC_Q_STEP_0P75,
            knees_reg[RC_B_K1I_LO +: 6]); // [R5]
        if (knees_reg[RC_B_K1I_LO +: 6] > RC_K1I_MAX) begin
            rsv = 1'b1; // [R5]
        end
        cfg_next.compress_knee_out_level = lin_qdb(RC_Q_ZERO, RC_Q_STEP_0P75,
            {1'b0, knees_reg[RC_B_K1O_LO +: 5]}); // [R6]
        if (knees_reg[RC_B_K1O_LO +: 5] > RC_K1O_MAX) begin
            rsv = 1'b1; // [R6]
        end
        cfg_next.reserved_code = rsv; // [R14]
    end

    // registered configuration output
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_cfg <= '0;
        end else begin
            o_cfg <= cfg_next;
        end
    end

    // strict threshold comparisons of the current sample
    assign peak_hit = i_crest_level > cfg_next.detect_peak_threshold; // [R13]
    assign rms_hit  = i_rms_level > cfg_next.detect_rms_threshold;    // [R1]

    // threshold comparison chosen by the mode bit
    always_comb begin
        det_next = o_signal_detect;
        if (!options_reg[RC_B_DET_EN]) begin
            det_next = 1'b0; // [R1]
        end else if (i_level_valid) begin
            if (options_reg[RC_B_MODE]) begin
                det_next = rms_hit; // [R1]
            end else begin
                det_next = peak_hit; // [R13]
            end
        end
    end

    // registered detect level
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_signal_detect <= 1'b0;
        end else begin
            o_signal_detect <= det_next;
        end
    end

    // sticky reserved-code flag, cleared by writing 1 to status bit 1; set wins
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sticky_reserved_reg <= 1'b0;
        end else if (cfg_next.reserved_code) begin
            sticky_reserved_reg <= 1'b1; // [R14]
        end else if (status_clear) begin
            sticky_reserved_reg <= 1'b0;
        end
    end

endmodule

/* File: logic/rc_pkg.sv */
// constants, types and register map of the range compressor configuration bank
package rc_pkg;
    typedef logic signed [11:0] rc_qdb_t;   // level in quarter-dB steps
    typedef logic [15:0]        rc_addr_t;
    typedef logic [31:0]        rc_word_t;

    // register byte addresses
    localparam rc_addr_t RC_OFS_OPTIONS = 16'hAB04;
    localparam rc_addr_t RC_OFS_GATE    = 16'hAB08;
    localparam rc_addr_t RC_OFS_KNEES   = 16'hAB0C;
    localparam rc_addr_t RC_OFS_STATUS  = 16'hAB10;

    // implemented bits and values after reset
    localparam rc_word_t RC_MASK_OPTIONS  = 32'h0000FFF8;
    localparam rc_word_t RC_MASK_GATE     = 32'h0000FFFF;
    localparam rc_word_t RC_MASK_KNEES    = 32'h1F1F3F1F;
    localparam rc_word_t RC_RST_OPTIONS   = 32'h00000018;
    localparam rc_word_t RC_RST_GATE      = 32'h00000018;
    localparam rc_word_t RC_RST_KNEES     = 32'h00000000;

    // field positions
    localparam int RC_B_RMS_LO  = 11;
    localparam int RC_B_PEAK_LO = 9;
    localparam int RC_B_GATE_EN = 8;
    localparam int RC_B_MODE    = 7;
    localparam int RC_B_DET_EN  = 6;
    localparam int RC_B_K2O_EN  = 5;
    localparam int RC_B_FR_EN   = 4;
    localparam int RC_B_CLIP_EN = 3;
    localparam int RC_B_FLOOR_LO = 12;
    localparam int RC_B_EXP_LO   = 10;
    localparam int RC_B_FRT_LO   = 8;
    localparam int RC_B_FRD_LO   = 6;
    localparam int RC_B_UPPER_LO = 3;
    localparam int RC_B_LOWER_LO = 0;
    localparam int RC_B_K2I_LO = 24;
    localparam int RC_B_K2O_LO = 16;
    localparam int RC_B_K1I_LO = 8;
    localparam int RC_B_K1O_LO = 0;

    // decode bases and steps, quarter-dB
    localparam rc_qdb_t RC_Q_RMS_BASE   = -12'sd120;
    localparam rc_qdb_t RC_Q_K2I_BASE   = -12'sd144;
    localparam rc_qdb_t RC_Q_FLOOR_BASE = -12'sd144;
    localparam rc_qdb_t RC_Q_PEAK_BASE  = 12'sd48;
    localparam rc_qdb_t RC_Q_ZERO       = 12'sd0;
    localparam rc_qdb_t RC_Q_STEP_6DB   = 12'sd24;
    localparam rc_qdb_t RC_Q_STEP_1P5   = -12'sd6;
    localparam rc_qdb_t RC_Q_STEP_0P75  = -12'sd3;
    localparam logic [5:0] RC_K1I_MAX   = 6'h3C;
    localparam logic [4:0] RC_K1O_MAX   = 5'h1E;
    localparam logic [3:0] RC_FLOOR_MAX = 4'hC;

    // fast release decay times, microseconds per 6 dB
    localparam logic [12:0] RC_US_DCY0 = 13'h02D5;
    localparam logic [12:0] RC_US_DCY1 = 13'h05AA;
    localparam logic [12:0] RC_US_DCY2 = 13'h16A8;

    // decoded configuration seen by the audio datapath; slopes in 1/16 units
    typedef struct packed {
        logic        detect_mode_select;
        logic        detect_enable;
        logic        gate_enable;
        logic        gate_knee_out_enable;
        logic        fast_release_enable;
        logic        clip_guard_enable;
        rc_qdb_t     detect_peak_threshold;
        rc_qdb_t     detect_rms_threshold;
        rc_qdb_t     gate_floor_gain;
        logic        gate_floor_apply;
        logic [3:0]  gate_expansion_slope;
        rc_qdb_t     fast_release_threshold;
        logic [12:0] fast_release_decay;
        logic [4:0]  upper_compress_slope;
        logic [4:0]  lower_compress_slope;
        rc_qdb_t     gate_knee_in_level;
        logic        gate_knee_in_active;
        rc_qdb_t     gate_knee_out_level;
        rc_qdb_t     compress_knee_in_level;
        rc_qdb_t     compress_knee_out_level;
        logic        reserved_code;
    } rc_cfg_s;
endpackage

/* File: testbench/rc_config_regs_properties.sv */
// concurrent property checker for the range compressor configuration bank
`timescale 1ns/10ps
module rc_config_regs_properties
    import rc_pkg::*;
(
    input wire logic       i_sys_clk,
    input wire logic       i_rst,
    input wire logic       i_psel,
    input wire logic       i_penable,
    input wire logic       i_pwrite,
    input wire rc_addr_t   i_paddr,
    input wire rc_word_t   i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic       i_level_valid,
    input wire rc_qdb_t    i_crest_level,
    input wire rc_qdb_t    i_rms_level,
    input wire logic       i_gate_active,
    input wire rc_word_t   o_prdata,
    input wire logic       o_pready,
    input wire logic       o_pslverr,
    input wire rc_cfg_s    o_cfg,
    input wire logic       o_signal_detect
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // a sample taken while the bus has left the settings alone for two edges
    sequence settled_s;
        !i_psel && !$past(i_psel) && i_level_valid && o_cfg.detect_enable;
    endsequence
    sequence peak_hit_s;
        settled_s ##0 (!o_cfg.detect_mode_select && i_crest_level > o_cfg.detect_peak_threshold);
    endsequence
    sequence rms_hit_s;
        settled_s ##0 (o_cfg.detect_mode_select && i_rms_level > o_cfg.detect_rms_threshold);
    endsequence
    peak_detect_a: assert property (peak_hit_s |=> o_signal_detect)
        else $error("crest above threshold not flagged");
    rms_detect_a: assert property (rms_hit_s |=> o_signal_detect)
        else $error("rms above threshold not flagged");
    detect_off_a: assert property (!o_cfg.detect_enable |-> !o_signal_detect)
        else $error("detect shown while disabled");
    knee_out_off_a: assert property (!o_cfg.gate_knee_out_enable |->
        o_cfg.gate_knee_out_level == 12'sd0) else $error("knee out level used while off");
    floor_apply_a: assert property (o_cfg.gate_enable && $past(i_gate_active) |->
        o_cfg.gate_floor_apply) else $error("floor gain not applied");
    expansion_set_a: assert property (!$past(i_rst) |->
        o_cfg.gate_expansion_slope inside {1, 2, 4, 8}) else $error("bad expansion");
    decay_set_a: assert property (!$past(i_rst) |->
        o_cfg.fast_release_decay inside {725, 1450, 5800}) else $error("bad decay");
    reset_decode_a: assert property ($fell(i_rst) |=> o_cfg.fast_release_enable &&
        o_cfg.upper_compress_slope == 5'h2 && o_cfg.lower_compress_slope == 5'h10)
        else $error("wrong decode after reset");
endmodule
bind rc_config_regs rc_config_regs_properties u_props (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .i_level_valid(i_level_valid), .i_crest_level(i_crest_level),
    .i_rms_level(i_rms_level), .i_gate_active(i_gate_active), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_cfg(o_cfg),
    .o_signal_detect(o_signal_detect));

/* File: testbench/tb_top.sv */
// self-checking bench for the range compressor configuration bank
`timescale 1ns/10ps
module tb_top;
    import rc_pkg::*;
    logic       i_sys_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, err;
    logic       i_level_valid, i_gate_active, o_signal_detect;
    logic [3:0] i_pstrb;
    rc_addr_t   i_paddr;
    rc_word_t   i_pwdata, o_prdata, rd;
    rc_qdb_t    i_crest_level, i_rms_level;
    rc_cfg_s    o_cfg;
    int         err_count, compares, cyc;

    rc_config_regs dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb), .i_level_valid(i_level_valid), .i_crest_level(i_crest_level),
        .i_rms_level(i_rms_level), .i_gate_active(i_gate_active), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_cfg(o_cfg),
        .o_signal_detect(o_signal_detect));

    // clock and hang guard
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input rc_addr_t a, input rc_word_t d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        i_psel    <= 1'h1;
        i_pwrite  <= wr;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'h1;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        rd = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'h0;
        i_penable <= 1'h0;
        if (n >= 50) begin
            err_count++;
            $display("Error at %0t: no ready from the register bank", $time);
        end
    endtask
    task automatic wait_cfg();
        repeat (2) @(posedge i_sys_clk);
    endtask

    // reset values, strobes, unmapped place
    task automatic t_regs();
        apb(0, 16'hAB04, 0);
        cmp(rd, 32'h00000018);
        apb(0, 16'hAB08, 0);
        cmp(rd, 32'h00000018);
        apb(0, 16'hAB0C, 0);
        cmp(rd, 32'h00000000);
        cmp(32'({o_cfg.detect_mode_select, o_cfg.detect_enable}), 32'h0);
        apb(1, 16'hAB0C, 32'hFFFFFFFF);
        apb(0, 16'hAB0C, 0);
        cmp(rd, 32'h1F1F3F1F);
        i_pstrb <= 4'h1;
        apb(1, 16'hAB0C, 32'h0);
        i_pstrb <= 4'hF;
        apb(0, 16'hAB0C, 0);
        cmp(rd, 32'h1F1F3F00);
        apb(0, 16'hAB14, 0);
        cmp({rd[30:0], err}, 32'h1);
        cmp(32'({o_cfg.fast_release_enable, o_cfg.clip_guard_enable}), 32'h3);
        apb(0, 16'hAB10, 0);
        cmp(rd, 32'h00000002);
        apb(1, 16'hAB10, 32'h00000002);
        apb(0, 16'hAB10, 0);
        cmp(rd, 32'h00000002);
    endtask
    // every knee-2 and knee-1 output code, even knee-1 input codes, knee out enabled, then disabled
    task automatic t_knees();
        apb(1, 16'hAB04, 32'h00000120);
        for (int c = 0; c < 32; c++) begin
            apb(1, 16'hAB0C, {3'h0, 5'(c), 3'h0, 5'(c), 2'h0, 6'(2 * c), 3'h0, 5'(c)});
            wait_cfg();
            cmp(32'(o_cfg.gate_knee_in_level), 32'(-144 - 6 * c));
            cmp(32'(o_cfg.gate_knee_out_level), 32'(-120 - 6 * c));
            cmp(32'(o_cfg.compress_knee_in_level), 32'(-6 * c));
            cmp(32'(o_cfg.compress_knee_out_level), 32'(-3 * c));
            cmp(32'(o_cfg.reserved_code), 32'(c == 31));
        end
        cmp(32'(o_cfg.gate_knee_in_active), 32'h1);
        apb(1, 16'hAB04, 32'h00000000);
        wait_cfg();
        cmp(32'(o_cfg.gate_knee_out_level), 32'h0);
        cmp(32'(o_cfg.gate_knee_in_active), 32'h0);
        apb(1, 16'hAB0C, 32'h0);
        apb(1, 16'hAB10, 32'h00000002);
        apb(0, 16'hAB10, 0);
        cmp(rd, 32'h00000000);
    endtask
    // gate, release and slope codes
    task automatic t_gate();
        logic [2:0] lo [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        int         ls [4] = '{16, 8, 4, 0};
        int         us [6] = '{16, 8, 4, 2, 1, 0};
        int         dy [3] = '{725, 1450, 5800};
        for (int i = 0; i < 14; i++) begin
            apb(1, 16'hAB08, {16'h0, 4'(i), 2'(i), 2'(i), 2'(i % 3), 3'(i % 6), lo[i % 4]});
            wait_cfg();
            cmp(32'(o_cfg.reserved_code), 32'(i == 13));
            if (i < 13) begin
                cmp(32'(o_cfg.gate_floor_gain), 32'(-144 + 24 * i));
                cmp(32'(o_cfg.gate_expansion_slope), 32'(1 << (i % 4)));
                cmp(32'(o_cfg.fast_release_threshold), 32'(48 + 24 * (i % 4)));
                cmp(32'(o_cfg.fast_release_decay), 32'(dy[i % 3]));
                cmp(32'(o_cfg.upper_compress_slope), 32'(us[i % 6]));
                cmp(32'(o_cfg.lower_compress_slope), 32'(ls[i % 4]));
            end
        end
    endtask
    task automatic smp(input rc_qdb_t cr, input rc_qdb_t rm, input logic exp);
        @(posedge i_sys_clk);
        i_level_valid <= 1'b1;
        i_crest_level <= cr;
        i_rms_level   <= rm;
        @(posedge i_sys_clk);
        i_level_valid <= 1'b0;
        @(posedge i_sys_clk);
        cmp(32'(o_signal_detect), 32'(exp));
    endtask
    // peak and rms detection at the threshold edge, disable, gate floor
    task automatic t_detect();
        apb(1, 16'hAB04, 32'h00001340);
        wait_cfg();
        smp(12'sd73, 12'sd0, 1'b1);
        smp(12'sd72, 12'sd0, 1'b0);
        apb(1, 16'hAB04, 32'h000013C0);
        wait_cfg();
        smp(12'sd0, -12'sd131, 1'b1);
        smp(12'sd0, -12'sd132, 1'b0);
        smp(12'sd0, -12'sd100, 1'b1);
        apb(1, 16'hAB04, 32'h00000180);
        wait_cfg();
        cmp(32'(o_signal_detect), 32'h0);
        i_gate_active <= 1'b1;
        wait_cfg();
        cmp(32'(o_cfg.gate_floor_apply), 32'h1);
        i_gate_active <= 1'b0;
        wait_cfg();
        cmp(32'(o_cfg.gate_floor_apply), 32'h0);
    endtask

    // main sequence
    initial begin
        {i_psel, i_penable, i_pwrite, i_level_valid, i_gate_active} = 5'h0;
        {i_paddr, i_pwdata, i_crest_level, i_rms_level} = '0;
        {err_count, compares, cyc} = '0;
        i_pstrb = 4'hF;
        i_rst = 1'b1;
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_regs();
        t_knees();
        t_gate();
        t_detect();
        finish_test();
    end
endmodule
